// >>> src/fcc_top.sv
// frame checker counters: management registers, path select, interrupt latch
// What this block does
// - checker runs only while enabled; resets enabled
// - select bit picks transmit path, else receive
// - count analysed frames and frame errors
// - receive error raises event when irq enabled
// - status bit latches on event until read
// - 16-bit error count, zero reset, clears on read
// - error read snapshots 32-bit frame count halves
// - count length errors, copy on error read
// - count alignment errors, copy on error read
// - count frames with receive error during valid
// - copies are read-only, reset zero; error copies 16-bit, frame copy 32-bit
`timescale 1ns/100ps
`default_nettype none
module fcc_top
    import fcc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [4:0] mgmt_dev_addr,
    input wire logic [15:0] mgmt_reg_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic rx_eof,
    input wire logic rx_crc_err,
    input wire logic rx_len_err,
    input wire logic rx_algn_err,
    input wire logic tx_dv,
    input wire logic tx_er,
    input wire logic tx_eof,
    input wire logic tx_crc_err,
    input wire logic tx_len_err,
    input wire logic tx_algn_err,
    output logic irq_out
);
    import fcc_pkg::*;

    logic enable_reg;
    logic irq_en_reg;
    logic src_sel_reg;
    logic mask_bit_reg;
    logic status_bit_reg;
    logic irq_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;

    logic dev_hit;
    logic wr_hit;
    logic rd_hit;
    logic snap;
    logic status_clr;
    logic err_event;
    logic [15:0] rdata_next;

    logic sel_dv;
    logic sel_er;
    logic sel_eof;
    logic sel_crc;
    logic sel_len;
    logic sel_algn;

    logic [FCC_CNT_W-1:0] rx_err_count;
    logic [FCC_FRM_W-1:0] frm_copy;
    logic [FCC_NUM_ERR-1:0][FCC_CNT_W-1:0] err_copy;

    fcc_evt_if evt ();

    // management access decode
    assign dev_hit = (mgmt_dev_addr == FCC_DEV_ADDR);
    assign wr_hit = mgmt_wr && dev_hit;
    assign rd_hit = mgmt_rd && dev_hit;
    assign snap = rd_hit && (mgmt_reg_addr == FCC_OFS_RX_ERR);
    assign status_clr = rd_hit && (mgmt_reg_addr == FCC_OFS_IRQ_STATUS);

    // path select; switching mid-frame may drop or split that frame
    always_comb begin
        if (src_sel_reg) begin
            sel_dv = tx_dv;
            sel_er = tx_er;
            sel_eof = tx_eof;
            sel_crc = tx_crc_err;
            sel_len = tx_len_err;
            sel_algn = tx_algn_err;
        end else begin
            sel_dv = rx_dv;
            sel_er = rx_er;
            sel_eof = rx_eof;
            sel_crc = rx_crc_err;
            sel_len = rx_len_err;
            sel_algn = rx_algn_err;
        end
    end

    fcc_frame_mon u_mon (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .enable(enable_reg),
        .dv(sel_dv),
        .er(sel_er),
        .eof(sel_eof),
        .crc_flag(sel_crc),
        .len_flag(sel_len),
        .algn_flag(sel_algn),
        .evt(evt.mon)
    );

    fcc_counter_bank u_bank (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .snap(snap),
        .evt(evt.bank),
        .rx_err_count(rx_err_count),
        .frm_copy(frm_copy),
        .err_copy(err_copy)
    );

    // control registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg <= FCC_RST_ENABLE;
            irq_en_reg <= FCC_RST_IRQ_EN;
            src_sel_reg <= FCC_RST_SRC_SEL;
            mask_bit_reg <= FCC_RST_MASK_BIT;
        end else if (ce && wr_hit) begin
            case (mgmt_reg_addr)
                FCC_OFS_ENABLE: enable_reg <= mgmt_wdata[FCC_CTRL_BIT];
                FCC_OFS_IRQ_EN: irq_en_reg <= mgmt_wdata[FCC_CTRL_BIT];
                FCC_OFS_SRC_SEL: src_sel_reg <= mgmt_wdata[FCC_CTRL_BIT];
                FCC_OFS_IRQ_MASK: mask_bit_reg <= mgmt_wdata[FCC_CG_IRQ_BIT];
                default: enable_reg <= enable_reg;
            endcase
        end
    end

    // any errored analysed frame is a receive error
    assign err_event = evt.frame_done && irq_en_reg
        && (evt.crc_err || (|evt.err_flags));

    // latched regardless of mask; a new event beats the read clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_bit_reg <= FCC_RST_STATUS_BIT;
        end else if (ce) begin
            if (err_event) begin
                status_bit_reg <= 1'b1;
            end else if (status_clr) begin
                status_bit_reg <= 1'b0;
            end
        end
    end

    // the host must also set the mask bit to see the pin
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= status_bit_reg && mask_bit_reg;
        end
    end

    // read data; unmapped offsets and reserved bits read zero
    always_comb begin
        rdata_next = FCC_ZERO_WORD;
        case (mgmt_reg_addr)
            FCC_OFS_ENABLE: rdata_next[FCC_CTRL_BIT] = enable_reg;
            FCC_OFS_IRQ_EN: rdata_next[FCC_CTRL_BIT] = irq_en_reg;
            FCC_OFS_SRC_SEL: rdata_next[FCC_CTRL_BIT] = src_sel_reg;
            FCC_OFS_IRQ_MASK: rdata_next[FCC_CG_IRQ_BIT] = mask_bit_reg;
            FCC_OFS_IRQ_STATUS: rdata_next[FCC_CG_IRQ_BIT] = status_bit_reg;
            FCC_OFS_RX_ERR: rdata_next = rx_err_count;
            FCC_OFS_FRM_HI: rdata_next = frm_copy[31:16];
            FCC_OFS_FRM_LO: rdata_next = frm_copy[15:0];
            FCC_OFS_LEN_ERR: rdata_next = err_copy[FCC_ERR_LEN];
            FCC_OFS_ALGN_ERR: rdata_next = err_copy[FCC_ERR_ALGN];
            FCC_OFS_SYMB_ERR: rdata_next = err_copy[FCC_ERR_SYMB];
            default: rdata_next = FCC_ZERO_WORD;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= FCC_ZERO_WORD;
            rvalid_reg <= 1'b0;
        end else if (ce) begin
            rvalid_reg <= rd_hit;
            if (rd_hit) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign mgmt_rdata = rdata_reg;
    assign mgmt_rvalid = rvalid_reg;
    assign irq_out = irq_reg;

    chk_status_on_event: assert property (
        @(posedge mclk) disable iff (!rst_n) ce && err_event |=> status_bit_reg)
        else $error("checker status bit not set by receive error");

    chk_status_holds: assert property (
        @(posedge mclk) disable iff (!rst_n)
        status_bit_reg && !(ce && status_clr) |=> status_bit_reg)
        else $error("checker status bit dropped without a read");

    chk_irq_gated_enable: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !irq_en_reg && !status_bit_reg && !status_clr |=> !status_bit_reg)
        else $error("status set while checker interrupt disabled");

    chk_read_answer: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && snap |=> mgmt_rvalid && mgmt_rdata == $past(rx_err_count))
        else $error("error count read returned wrong value");

    chk_irq_follows: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && err_event ##1 ce && mask_bit_reg |=> irq_out)
        else $error("masked-in checker event did not reach the pin");

    chk_source_select: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && enable_reg && (src_sel_reg ? tx_eof && tx_dv : rx_eof && rx_dv)
        |=> evt.frame_done)
        else $error("frame on the selected path not seen");

    // writes land at the next edge
    chk_enable_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && wr_hit && mgmt_reg_addr == FCC_OFS_ENABLE
        |=> enable_reg == $past(mgmt_wdata[FCC_CTRL_BIT]))
        else $error("enable write did not land");

    chk_select_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && wr_hit && mgmt_reg_addr == FCC_OFS_SRC_SEL
        |=> src_sel_reg == $past(mgmt_wdata[FCC_CTRL_BIT]))
        else $error("source select write did not land");

    chk_irq_en_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && wr_hit && mgmt_reg_addr == FCC_OFS_IRQ_EN
        |=> irq_en_reg == $past(mgmt_wdata[FCC_CTRL_BIT]))
        else $error("interrupt enable write did not land");

    chk_mask_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && wr_hit && mgmt_reg_addr == FCC_OFS_IRQ_MASK
        |=> mask_bit_reg == $past(mgmt_wdata[FCC_CG_IRQ_BIT]))
        else $error("mask write did not land");

    chk_path_ignored: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !(src_sel_reg ? tx_eof : rx_eof) |=> !evt.frame_done)
        else $error("frame counted from the unselected path");

    chk_status_clears: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && status_clr && !err_event |=> !status_bit_reg)
        else $error("checker status bit not cleared by read");

    chk_irq_needs_mask: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !mask_bit_reg |=> !irq_out)
        else $error("checker interrupt reached the pin while masked");

    chk_count_holds: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !snap && !evt.frame_done |=> rx_err_count == $past(rx_err_count))
        else $error("receive error count changed without read or frame");

    // read answers carry the addressed copy
    chk_high_copy_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && rd_hit && mgmt_reg_addr == FCC_OFS_FRM_HI
        |=> mgmt_rdata == $past(frm_copy[31:16]))
        else $error("frame count high copy read wrong");

    chk_low_copy_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && rd_hit && mgmt_reg_addr == FCC_OFS_FRM_LO
        |=> mgmt_rdata == $past(frm_copy[15:0]))
        else $error("frame count low copy read wrong");

    chk_length_copy_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && rd_hit && mgmt_reg_addr == FCC_OFS_LEN_ERR
        |=> mgmt_rdata == $past(err_copy[FCC_ERR_LEN]))
        else $error("length error copy read wrong");

    chk_align_copy_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && rd_hit && mgmt_reg_addr == FCC_OFS_ALGN_ERR
        |=> mgmt_rdata == $past(err_copy[FCC_ERR_ALGN]))
        else $error("alignment error copy read wrong");

    chk_symbol_copy_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && rd_hit && mgmt_reg_addr == FCC_OFS_SYMB_ERR
        |=> mgmt_rdata == $past(err_copy[FCC_ERR_SYMB]))
        else $error("symbol error copy read wrong");
endmodule
`default_nettype wire

// >>> src/fcc_pkg.sv
// constants and types for the frame checker counter block
package fcc_pkg;
    localparam logic [4:0] FCC_DEV_ADDR = 5'h1F;
    localparam logic [15:0] FCC_OFS_IRQ_STATUS = 16'h0011;
    localparam logic [15:0] FCC_OFS_IRQ_MASK = 16'h0021;
    localparam logic [15:0] FCC_OFS_ENABLE = 16'h8001;
    localparam logic [15:0] FCC_OFS_IRQ_EN = 16'h8004;
    localparam logic [15:0] FCC_OFS_SRC_SEL = 16'h8005;
    localparam logic [15:0] FCC_OFS_RX_ERR = 16'h8008;
    localparam logic [15:0] FCC_OFS_FRM_HI = 16'h8009;
    localparam logic [15:0] FCC_OFS_FRM_LO = 16'h800A;
    localparam logic [15:0] FCC_OFS_LEN_ERR = 16'h800B;
    localparam logic [15:0] FCC_OFS_ALGN_ERR = 16'h800C;
    localparam logic [15:0] FCC_OFS_SYMB_ERR = 16'h800D;
    localparam int FCC_CTRL_BIT = 0;
    localparam int FCC_CG_IRQ_BIT = 14;
    localparam int FCC_CNT_W = 16;
    localparam int FCC_FRM_W = 32;
    localparam int FCC_NUM_ERR = 3;
    localparam int FCC_ERR_LEN = 0;
    localparam int FCC_ERR_ALGN = 1;
    localparam int FCC_ERR_SYMB = 2;
    localparam logic FCC_RST_ENABLE = 1'b1;
    localparam logic FCC_RST_IRQ_EN = 1'b1;
    localparam logic FCC_RST_SRC_SEL = 1'b0;
    localparam logic FCC_RST_MASK_BIT = 1'b0;
    localparam logic FCC_RST_STATUS_BIT = 1'b0;
    localparam logic [15:0] FCC_RST_CNT = 16'h0000;
    localparam logic [31:0] FCC_RST_FRM = 32'h0000_0000;
    localparam logic [15:0] FCC_ZERO_WORD = 16'h0000;
    typedef logic [FCC_CNT_W-1:0] fcc_cnt_t;
    typedef enum logic {
        FCC_IDLE = 1'b0,
        FCC_IN_FRAME = 1'b1
    } fcc_mon_state_t;
endpackage

// >>> src/fcc_evt_if.sv
// frame event carrier between frame monitor and counter bank
`timescale 1ns/100ps
`default_nettype none
interface fcc_evt_if;
    logic frame_done;
    logic crc_err;
    logic [2:0] err_flags;
    modport mon (output frame_done, output crc_err, output err_flags);
    modport bank (input frame_done, input crc_err, input err_flags);
endinterface
`default_nettype wire

// >>> src/fcc_frame_mon.sv
// frame monitor: turns a selected frame stream into per-frame events
`timescale 1ns/100ps
`default_nettype none
module fcc_frame_mon
    import fcc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic enable,
    input wire logic dv,
    input wire logic er,
    input wire logic eof,
    input wire logic crc_flag,
    input wire logic len_flag,
    input wire logic algn_flag,
    fcc_evt_if.mon evt
);
    fcc_mon_state_t state_reg;
    logic sym_seen_reg;
    logic sym_now;

    // symbol error seen in the closing cycle counts too
    assign sym_now = sym_seen_reg | (dv & er);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= FCC_IDLE;
        end else if (ce) begin
            if (!enable) begin
                state_reg <= FCC_IDLE;
            end else begin
                case (state_reg)
                    FCC_IDLE: state_reg <= (dv && !eof) ? FCC_IN_FRAME : FCC_IDLE;
                    FCC_IN_FRAME: state_reg <= eof ? FCC_IDLE : FCC_IN_FRAME;
                    default: state_reg <= FCC_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sym_seen_reg <= 1'b0;
        end else if (ce) begin
            if (!enable || eof) begin
                sym_seen_reg <= 1'b0;
            end else if (dv && er) begin
                sym_seen_reg <= 1'b1;
            end
        end
    end

    // a frame ends with eof while dv started it; stray eof is ignored
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt.frame_done <= 1'b0;
            evt.crc_err <= 1'b0;
            evt.err_flags <= 3'h0;
        end else if (ce) begin
            evt.frame_done <= enable && eof && (state_reg == FCC_IN_FRAME || dv);
            evt.crc_err <= crc_flag;
            evt.err_flags[FCC_ERR_LEN] <= len_flag;
            evt.err_flags[FCC_ERR_ALGN] <= algn_flag;
            evt.err_flags[FCC_ERR_SYMB] <= sym_now;
        end
    end

    chk_disabled_no_event: assert property (
        @(posedge mclk) disable iff (!rst_n) ce && !enable |=> !evt.frame_done)
        else $error("frame event while checker disabled");

    chk_symbol_error_flag: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && enable && state_reg == FCC_IN_FRAME && dv && er && eof
        |=> evt.frame_done && evt.err_flags[FCC_ERR_SYMB])
        else $error("symbol error in frame not flagged");
endmodule
`default_nettype wire

// >>> src/fcc_counter_bank.sv
// live counters and their snapshot copies
`timescale 1ns/100ps
`default_nettype none
module fcc_counter_bank
    import fcc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic snap,
    fcc_evt_if.bank evt,
    output logic [FCC_CNT_W-1:0] rx_err_count,
    output logic [FCC_FRM_W-1:0] frm_copy,
    output logic [FCC_NUM_ERR-1:0][FCC_CNT_W-1:0] err_copy
);
    logic [FCC_FRM_W-1:0] frm_live_reg;
    logic [FCC_FRM_W-1:0] frm_copy_reg;
    logic [FCC_CNT_W-1:0] rx_err_reg;
    logic err_hit;

    assign err_hit = evt.frame_done && (evt.crc_err || (|evt.err_flags));
    assign rx_err_count = rx_err_reg;
    assign frm_copy = frm_copy_reg;

    // a frame error in the read cycle survives the clear as a count of one
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_err_reg <= FCC_RST_CNT;
        end else if (ce) begin
            if (snap) begin
                rx_err_reg <= err_hit ? 16'h0001 : FCC_RST_CNT;
            end else if (err_hit) begin
                rx_err_reg <= rx_err_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            frm_live_reg <= FCC_RST_FRM;
            frm_copy_reg <= FCC_RST_FRM;
        end else if (ce) begin
            if (evt.frame_done) begin
                frm_live_reg <= frm_live_reg + 32'h0000_0001;
            end
            if (snap) begin
                frm_copy_reg <= frm_live_reg;
            end
        end
    end

    for (genvar g = 0; g < FCC_NUM_ERR; g++) begin : g_err
        logic [FCC_CNT_W-1:0] live_reg;
        logic [FCC_CNT_W-1:0] copy_reg;
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                live_reg <= FCC_RST_CNT;
                copy_reg <= FCC_RST_CNT;
            end else if (ce) begin
                if (evt.frame_done && evt.err_flags[g]) begin
                    live_reg <= live_reg + 16'h0001;
                end
                if (snap) begin
                    copy_reg <= live_reg;
                end
            end
        end
        assign err_copy[g] = copy_reg;
    end

    chk_read_clears: assert property (
        @(posedge mclk) disable iff (!rst_n) ce && snap && !err_hit |=> rx_err_reg == 16'h0000)
        else $error("receive error count not cleared by read");

    chk_frame_snapshot: assert property (
        @(posedge mclk) disable iff (!rst_n) ce && snap |=> frm_copy_reg == $past(frm_live_reg))
        else $error("frame count copy differs from live count");

    chk_copies_stable: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !(ce && snap) |=> $stable(frm_copy_reg) && $stable(err_copy))
        else $error("copy changed without a snapshot");

    chk_frame_count_step: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && evt.frame_done |=> frm_live_reg == $past(frm_live_reg) + 32'h0000_0001)
        else $error("frame count did not advance");
endmodule
`default_nettype wire

// >>> sim/fcc_frame_src.sv
// frame source model for one checker path
`timescale 1ns/100ps
`default_nettype none
module fcc_frame_src (
    input wire logic mclk,
    output logic dv,
    output logic er,
    output logic eof,
    output logic crc_err,
    output logic len_err,
    output logic algn_err
);
    logic busy = 1'b0;
    initial begin
        {dv, er, eof, crc_err, len_err, algn_err} = 6'h00;
    end
    // flags mean nothing outside eof, so they wander instead of holding
    always @(negedge mclk) begin
        if (!busy) begin
            er <= ~er;
            crc_err <= ~crc_err ^ er;
            len_err <= ~len_err;
            algn_err <= crc_err;
        end
    end
    // n cycles of valid, eof on the last, error marker at cycle ea
    task automatic send(input int n, input int ea, input logic [2:0] f);
        int i;
        busy = 1'b1;
        for (i = 0; i < n; i++) begin
            @(negedge mclk);
            dv = 1'b1;
            er = (i == ea);
            eof = (i == n - 1);
            {crc_err, len_err, algn_err} = (i == n - 1) ? f : ~f;
        end
        @(negedge mclk);
        dv = 1'b0;
        eof = 1'b0;
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the frame checker counters
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fcc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n, ce, mgmt_wr, mgmt_rd, mgmt_rvalid, irq_out;
    logic [4:0] mgmt_dev_addr;
    logic [15:0] mgmt_reg_addr, mgmt_wdata, mgmt_rdata;
    logic rx_dv, rx_er, rx_eof, rx_crc_err, rx_len_err, rx_algn_err;
    logic tx_dv, tx_er, tx_eof, tx_crc_err, tx_len_err, tx_algn_err;
    logic [31:0] exp_q[$];
    logic [31:0] q, m_frm, c_frm;
    logic [15:0] m_err, m_len, m_algn, m_symb, c_len, c_algn, c_symb;
    logic m_en, m_sel, m_irqen, m_st;
    int n_fail = 0, compares = 0, seed = 70, cyc = 0, i;
    logic [15:0] ra [12] = '{FCC_OFS_ENABLE, FCC_OFS_IRQ_EN, FCC_OFS_SRC_SEL, FCC_OFS_RX_ERR,
        FCC_OFS_FRM_HI, FCC_OFS_FRM_LO, FCC_OFS_LEN_ERR, FCC_OFS_ALGN_ERR, FCC_OFS_SYMB_ERR,
        FCC_OFS_IRQ_STATUS, FCC_OFS_IRQ_MASK, 16'h8002};
    logic [15:0] rv [12] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    fcc_top DUT (.*);
    fcc_frame_src rx_src (.mclk(mclk), .dv(rx_dv), .er(rx_er), .eof(rx_eof),
        .crc_err(rx_crc_err), .len_err(rx_len_err), .algn_err(rx_algn_err));
    fcc_frame_src tx_src (.mclk(mclk), .dv(tx_dv), .er(tx_er), .eof(tx_eof),
        .crc_err(tx_crc_err), .len_err(tx_len_err), .algn_err(tx_algn_err));

    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // answers are matched in order against the notes left by rd
    always @(negedge mclk) begin
        if (mgmt_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("mgmt_rvalid", 16'h0000, 16'h0001);
            end else begin
                q = exp_q.pop_front();
                chk($sformatf("reg %h", q[31:16]), q[15:0], mgmt_rdata);
            end
        end
    end
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(negedge mclk);
        mgmt_rd = 1'b1;
        mgmt_reg_addr = a;
        exp_q.push_back({a, e});
        @(negedge mclk);
        mgmt_rd = 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk);
        mgmt_wr = 1'b1;
        mgmt_reg_addr = a;
        mgmt_wdata = d;
        @(negedge mclk);
        mgmt_wr = 1'b0;
    endtask
    task automatic frame(input logic path, input logic [2:0] f, input int n, input int ea);
        logic e;
        e = (|f) || (ea < n);
        if (path) tx_src.send(n, ea, f);
        else rx_src.send(n, ea, f);
        if (m_en && path == m_sel) begin
            m_frm = m_frm + 32'h1;
            m_err = m_err + 16'(e);
            m_len = m_len + 16'(f[1]);
            m_algn = m_algn + 16'(f[0]);
            m_symb = m_symb + 16'(ea < n);
            if (e && m_irqen) m_st = 1'b1;
        end
        repeat (4) @(negedge mclk);
    endtask
    task automatic burst(input logic path, input int k);
        int j, n;
        for (j = 0; j < k; j++) begin
            n = 2 + ($unsigned($random(seed)) % 4);
            frame(path, 3'($random(seed)), n, $unsigned($random(seed)) % (n + 2));
        end
    endtask
    task automatic snap();
        rd(FCC_OFS_RX_ERR, m_err);
        c_frm = m_frm;
        c_len = m_len;
        c_algn = m_algn;
        c_symb = m_symb;
        m_err = 16'h0000;
    endtask
    task automatic copies();
        rd(FCC_OFS_FRM_HI, c_frm[31:16]);
        rd(FCC_OFS_FRM_LO, c_frm[15:0]);
        rd(FCC_OFS_LEN_ERR, c_len);
        rd(FCC_OFS_ALGN_ERR, c_algn);
        rd(FCC_OFS_SYMB_ERR, c_symb);
    endtask
    task automatic stop_test();
        repeat (4) @(negedge mclk);
        if (exp_q.size() != 0) n_fail++;
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_dev_addr = FCC_DEV_ADDR;
        mgmt_reg_addr = 16'h0000;
        mgmt_wdata = 16'h0000;
        {m_frm, c_frm} = 64'h0;
        {m_err, m_len, m_algn, m_symb, c_len, c_algn, c_symb} = 112'h0;
        {m_en, m_sel, m_irqen, m_st} = 4'b1010;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        for (i = 0; i < 12; i++) rd(ra[i], rv[i]);
        wr(FCC_OFS_FRM_HI, 16'hFFFF);
        rd(FCC_OFS_FRM_HI, 16'h0000);
        burst(1'b0, 10);
        snap();
        copies();
        burst(1'b0, 3);
        copies();
        snap();
        copies();
        rd(FCC_OFS_IRQ_STATUS, {1'b0, m_st, 14'h0});
        m_st = 1'b0;
        rd(FCC_OFS_IRQ_STATUS, 16'h0000);
        wr(FCC_OFS_SRC_SEL, 16'hFFFF);
        m_sel = 1'b1;
        rd(FCC_OFS_SRC_SEL, 16'h0001);
        burst(1'b1, 4);
        burst(1'b0, 2);
        snap();
        copies();
        wr(FCC_OFS_ENABLE, 16'h0000);
        m_en = 1'b0;
        burst(1'b1, 3);
        snap();
        wr(FCC_OFS_ENABLE, 16'h0001);
        m_en = 1'b1;
        wr(FCC_OFS_IRQ_MASK, 16'h4000);
        rd(FCC_OFS_IRQ_MASK, 16'h4000);
        rd(FCC_OFS_IRQ_STATUS, {1'b0, m_st, 14'h0});
        m_st = 1'b0;
        frame(1'b1, 3'b010, 3, 9);
        chk("irq_out", 16'h0001, 16'(irq_out));
        rd(FCC_OFS_IRQ_STATUS, 16'h4000);
        m_st = 1'b0;
        repeat (2) @(negedge mclk);
        chk("irq_out", 16'h0000, 16'(irq_out));
        wr(FCC_OFS_IRQ_EN, 16'h0000);
        m_irqen = 1'b0;
        frame(1'b1, 3'b001, 2, 0);
        rd(FCC_OFS_IRQ_STATUS, 16'h0000);
        chk("irq_out", 16'h0000, 16'(irq_out));
        // another device address must stay unanswered
        @(negedge mclk);
        mgmt_dev_addr = 5'h00;
        mgmt_rd = 1'b1;
        @(negedge mclk);
        mgmt_rd = 1'b0;
        mgmt_dev_addr = FCC_DEV_ADDR;
        // low clock enable freezes all: no answer, no clear, no count
        @(negedge mclk);
        ce = 1'b0;
        mgmt_rd = 1'b1;
        mgmt_reg_addr = FCC_OFS_RX_ERR;
        @(negedge mclk);
        mgmt_rd = 1'b0;
        m_en = 1'b0;
        frame(1'b1, 3'b100, 2, 5);
        m_en = 1'b1;
        ce = 1'b1;
        snap();
        copies();
        stop_test();
    end
endmodule
`default_nettype wire
